// >>> common/miac_pkg.sv
// Register map, field positions and carriers of the interrupt/axis block
package miac_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_DATA_READY_PIN   = 8'h48;
  localparam logic [7:0] ADDR_RH_MSB = 8'h49;
  localparam logic [7:0] ADDR_STAT   = 8'h4A;
  localparam logic [7:0] ADDR_IEN    = 8'h4D;
  localparam logic [7:0] ADDR_PAC    = 8'h4E;
  localparam logic [7:0] ADDR_LOW    = 8'h4F;
  localparam logic [7:0] ADDR_HIGH   = 8'h50;

  // Interrupt settings fields
  localparam int unsigned IEN_OVR    = 7;
  localparam int unsigned IEN_OVF    = 6;
  localparam int unsigned IEN_HI_LSB = 3;
  localparam int unsigned IEN_LO_LSB = 0;

  // Pin and axis control fields
  localparam int unsigned PAC_DATA_READY_PIN_EN = 7;
  localparam int unsigned PAC_INT_EN  = 6;
  localparam int unsigned PAC_CH_Z    = 5;
  localparam int unsigned PAC_CH_Y    = 4;
  localparam int unsigned PAC_CH_X    = 3;
  localparam int unsigned PAC_DRPOL   = 2;
  localparam int unsigned PAC_LATCH   = 1;
  localparam int unsigned PAC_INTPOL  = 0;

  // Status fields; threshold flags occupy bits 5:0
  localparam int unsigned STAT_OVR = 7;
  localparam int unsigned STAT_OVF = 6;

  // Reset values
  localparam logic [7:0] IEN_RST = 8'h3F;
  localparam logic [7:0] PAC_RST = 8'h07;
  localparam logic [7:0] LIM_RST = 8'h00;

  // Limit scaling: limit value shifted left by this many bits
  localparam int unsigned LIM_SHIFT_DEF = 4;

  typedef struct packed {
    logic        write;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } miac_req_t;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
    logic        [13:0] rhall;
    logic               ovf;
  } miac_meas_t;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
    logic        [13:0] rhall;
  } miac_data_t;

endpackage : miac_pkg

// >>> rtl/miac_core.sv
// Interrupt, pin mapping and axis control core with link-side register port
module miac_core #(
  parameter int unsigned LIM_SHIFT = miac_pkg::LIM_SHIFT_DEF
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_lclk,
  input  wire logic                 i_req_valid,
  input  wire miac_pkg::miac_req_t  i_req,
  output logic                      o_req_ready,
  output logic                      o_rsp_valid,
  output logic [7:0]                o_rsp_data,
  input  wire logic                 i_meas_valid,
  input  wire miac_pkg::miac_meas_t i_meas,
  output miac_pkg::miac_data_t      o_data,
  output logic                      o_data_ready_pin,
  output logic                      o_int_pin
);
  import miac_pkg::*;

  logic [1:0] lrst_s;
  logic       lrst_n;
  logic       req_tgl;
  logic       busy;
  logic [2:0] ack_s;
  logic       ack_lvl;
  logic       rsp_done;
  miac_req_t  req_hold;
  logic [2:0] req_s;
  logic       req_lvl;
  logic       ack_tgl;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       rd_stat;
  logic       rd_data_ready_pin;
  logic [7:0] rdata;
  logic [7:0] ien;
  logic [7:0] pac;
  logic [7:0] low_lim;
  logic [7:0] high_lim;
  logic       data_ready_pin;
  logic       eval;
  logic       ovf_cond;
  logic       ovr_evt;
  logic [2:0] hi_hit;
  logic [2:0] lo_hit;
  logic [5:0] thr_cond;
  logic [7:0] status;
  logic [7:0] next_status;
  logic       int_act;
  logic       rdy_act;

  // Link reset: asserts at once, releases on the link clock
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lrst_s <= 2'h0;
    end else begin
      lrst_s <= {lrst_s[0], 1'h1};
    end
  end
  assign lrst_n = lrst_s[1];

  // Acknowledge toggle into the link domain, filtered
  always_ff @(posedge i_lclk or negedge lrst_n) begin
    if (!lrst_n) begin
      ack_s   <= 3'h0;
      ack_lvl <= 1'h0;
    end else begin
      ack_s <= {ack_s[1:0], ack_tgl};
      if (ack_s[2] == ack_s[1]) begin
        ack_lvl <= ack_s[2];
      end
    end
  end

  // One access in flight; the held request is stable until acked
  assign o_req_ready = !busy;
  assign rsp_done    = busy && (ack_lvl == req_tgl);

  always_ff @(posedge i_lclk or negedge lrst_n) begin
    if (!lrst_n) begin
      req_tgl  <= 1'h0;
      busy     <= 1'h0;
      req_hold <= '0;
    end else if (i_req_valid && !busy) begin
      req_hold <= i_req;
      req_tgl  <= !req_tgl;
      busy     <= 1'h1;
    end else if (rsp_done) begin
      busy <= 1'h0;
    end
  end

  // Read data is held by the core until the next response
  always_ff @(posedge i_lclk or negedge lrst_n) begin
    if (!lrst_n) begin
      o_rsp_valid <= 1'h0;
      o_rsp_data  <= 8'h00;
    end else begin
      o_rsp_valid <= rsp_done;
      if (rsp_done) begin
        o_rsp_data <= rdata;
      end
    end
  end

  // Request toggle into the core domain, filtered
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_s   <= 3'h0;
      req_lvl <= 1'h0;
    end else begin
      req_s <= {req_s[1:0], req_tgl};
      if (req_s[2] == req_s[1]) begin
        req_lvl <= req_s[2];
      end
    end
  end

  assign acc     = req_lvl != ack_tgl;
  assign wr      = acc && req_hold.write;
  assign rd      = acc && !req_hold.write;
  assign rd_stat = rd && (req_hold.addr == ADDR_STAT);
  assign rd_data_ready_pin = rd && (req_hold.addr == ADDR_DATA_READY_PIN);

  // Register read mux; unmapped offsets read zero
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    if (a == ADDR_DATA_READY_PIN) begin
      return {o_data.rhall[5:0], 1'h0, data_ready_pin};
    end else if (a == ADDR_RH_MSB) begin
      return o_data.rhall[13:6];
    end else if (a == ADDR_STAT) begin
      return status;
    end else if (a == ADDR_IEN) begin
      return ien;
    end else if (a == ADDR_PAC) begin
      return pac;
    end else if (a == ADDR_LOW) begin
      return low_lim;
    end else if (a == ADDR_HIGH) begin
      return high_lim;
    end else begin
      return 8'h00;
    end
  endfunction : read_mux

  // Perform the access once, then hand the ack back
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_tgl <= 1'h0;
      rdata   <= 8'h00;
    end else if (acc) begin
      ack_tgl <= req_lvl;
      if (rd) begin
        rdata <= read_mux(req_hold.addr);
      end
    end
  end

  // Control registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ien      <= IEN_RST;
      pac      <= PAC_RST;
      low_lim  <= LIM_RST;
      high_lim <= LIM_RST;
    end else if (wr) begin
      if (req_hold.addr == ADDR_IEN) begin
        ien <= req_hold.wdata;
      end else if (req_hold.addr == ADDR_PAC) begin
        pac <= req_hold.wdata;
      end else if (req_hold.addr == ADDR_LOW) begin
        low_lim <= req_hold.wdata;
      end else if (req_hold.addr == ADDR_HIGH) begin
        high_lim <= req_hold.wdata;
      end
    end
  end

  // Result registers; a disabled channel stops updating, and z off also forces rhall to zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data   <= '0;
      ovf_cond <= 1'h0;
    end else begin
      if (i_meas_valid) begin
        ovf_cond <= i_meas.ovf;
        if (!pac[PAC_CH_X]) begin
          o_data.x <= i_meas.x;
        end
        if (!pac[PAC_CH_Y]) begin
          o_data.y <= i_meas.y;
        end
        if (!pac[PAC_CH_Z]) begin
          o_data.z <= i_meas.z;
        end
      end
      if (pac[PAC_CH_Z]) begin
        o_data.rhall <= 14'h0000;
      end else if (i_meas_valid) begin
        o_data.rhall <= i_meas.rhall;
      end
    end
  end

  // Data ready: a new result wins over a same-cycle read
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_ready_pin <= 1'h0;
      eval <= 1'h0;
    end else begin
      eval <= i_meas_valid;
      if (i_meas_valid) begin
        data_ready_pin <= 1'h1;
      end else if (rd_data_ready_pin) begin
        data_ready_pin <= 1'h0;
      end
    end
  end

  // Signed compare of a value against a scaled limit
  function automatic logic lim_hit(input logic signed [15:0] v,
                                   input logic [7:0] lim,
                                   input logic hi);
    logic signed [23:0] sv;
    logic signed [23:0] sl;
    sv = 24'(v);
    sl = 24'(signed'(lim)) <<< LIM_SHIFT;
    return hi ? (sv > sl) : (sv < sl);
  endfunction : lim_hit

  // Held values are compared, so disabled axes keep firing
  assign hi_hit = {lim_hit(o_data.z, high_lim, 1'h1),
                   lim_hit(o_data.y, high_lim, 1'h1),
                   lim_hit(o_data.x, high_lim, 1'h1)};
  assign lo_hit = {lim_hit(o_data.z, low_lim, 1'h0),
                   lim_hit(o_data.y, low_lim, 1'h0),
                   lim_hit(o_data.x, low_lim, 1'h0)};
  assign thr_cond = {hi_hit, lo_hit} & ~ien[5:0];
  assign ovr_evt  = i_meas_valid && data_ready_pin && ien[IEN_OVR];

  // Status: bits 6:0 sticky when latched, level when not; overrun bit always sticky; set beats clear
  always_comb begin
    next_status = status;
    if (rd_stat) begin
      next_status = 8'h00;
    end
    if (pac[PAC_LATCH]) begin
      if (eval) begin
        next_status[6:0] = next_status[6:0] | {ovf_cond, thr_cond};
      end
    end else begin
      next_status[6:0] = {ovf_cond, thr_cond};
    end
    if (ovr_evt) begin
      next_status[STAT_OVR] = 1'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status <= 8'h00;
    end else begin
      status <= next_status;
    end
  end

  // Pin terms; pins are registered to stay glitch free
  assign int_act = pac[PAC_INT_EN] &&
                   |(status & {ien[IEN_OVR], ien[IEN_OVF], 6'h3F});
  assign rdy_act = pac[PAC_DATA_READY_PIN_EN] && data_ready_pin;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_int_pin        <= 1'h0;
      o_data_ready_pin <= 1'h0;
    end else begin
      o_int_pin        <= pac[PAC_INTPOL] ? int_act : !int_act;
      o_data_ready_pin <= pac[PAC_DRPOL] ? rdy_act : !rdy_act;
    end
  end

  // Checks on the core clock, except the response pulse check on the link clock
  default clocking cb_m @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_wr_low;
    wr && (req_hold.addr == ADDR_LOW);
  endsequence
  sequence s_wr_high;
    wr && (req_hold.addr == ADDR_HIGH);
  endsequence
  sequence s_latched_held;
    pac[PAC_LATCH] && status[0] && !rd_stat;
  endsequence

  chk_ovr_gate: assert property (
    $rose(status[STAT_OVR]) |-> $past(ien[IEN_OVR]) && $past(data_ready_pin))
    else $error("overrun flag set while disabled");
  chk_ovf_route: assert property (
    (status == 8'h40) && pac[PAC_INT_EN] && pac[PAC_INTPOL]
    |=> o_int_pin == $past(ien[IEN_OVF]))
    else $error("overflow routing to pin wrong");
  chk_hi_mask: assert property (
    ((status[5:3] & ~$past(status[5:3])) & $past(ien[5:3])) == 3'h0)
    else $error("high flag set on disabled axis");
  chk_lo_mask: assert property (
    ((status[2:0] & ~$past(status[2:0])) & $past(ien[2:0])) == 3'h0)
    else $error("low flag set on disabled axis");
  chk_chan_hold: assert property (
    i_meas_valid && pac[PAC_CH_X] |=> o_data.x == $past(o_data.x))
    else $error("disabled x channel changed");
  chk_rhall_zero: assert property (
    pac[PAC_CH_Z] |=> o_data.rhall == 14'h0000)
    else $error("resistance not zero with z off");
  chk_stale_axis: assert property (
    eval && pac[PAC_CH_X] && !ien[0] && lo_hit[0] |=> status[0])
    else $error("disabled axis did not interrupt");
  chk_rdy_gate: assert property (
    !pac[PAC_DATA_READY_PIN_EN] |=> o_data_ready_pin == !$past(pac[PAC_DRPOL]))
    else $error("data-ready pin active while unmapped");
  chk_int_gate: assert property (
    !pac[PAC_INT_EN] |=> o_int_pin == !$past(pac[PAC_INTPOL]))
    else $error("interrupt pin active while unmapped");
  chk_rdy_pol: assert property (
    pac[PAC_DATA_READY_PIN_EN] && data_ready_pin |=> o_data_ready_pin == $past(pac[PAC_DRPOL]))
    else $error("data-ready pin polarity wrong");
  chk_latch_hold: assert property (
    s_latched_held |=> status[0])
    else $error("latched flag dropped before read");
  chk_read_clear: assert property (
    rd_stat && pac[PAC_LATCH] && !eval |=> status[5:0] == 6'h00)
    else $error("status read did not clear flags");
  chk_low_write: assert property (
    s_wr_low |=> low_lim == $past(req_hold.wdata))
    else $error("low limit not written");
  chk_high_write: assert property (
    s_wr_high |=> high_lim == $past(req_hold.wdata))
    else $error("high limit not written");
  chk_data_ready_pin_read: assert property (
    rd_data_ready_pin |=> rdata[0] == $past(data_ready_pin))
    else $error("data-ready bit read wrong");
  chk_rsp_pulse: assert property (
    @(posedge i_lclk) disable iff (!lrst_n)
    o_rsp_valid |=> !o_rsp_valid)
    else $error("response valid longer than one cycle");

endmodule : miac_core

// >>> tb/miac_host.sv
// Host model offering register accesses on the link clock
module miac_host
  import miac_pkg::*;
(
  input  wire logic       i_lclk,
  output logic            o_req_valid,
  output miac_req_t       o_req,
  input  wire logic       i_req_ready,
  input  wire logic       i_rsp_valid,
  input  wire logic [7:0] i_rsp_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle request at time zero
  initial begin
    o_req_valid = 1'b0;
    o_req       = '0;
  end

  // One access: offer, hold to the taking edge, wait a bounded time
  task automatic access(input logic wr, input logic [7:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge i_lclk);
    #1;
    o_req_valid = 1'b1;
    o_req       = '{write: wr, addr: addr, wdata: wdata};
    // Hold the offer until the core shows ready ahead of an edge
    for (int w = 0; w < 40 && i_req_ready !== 1'b1; w++) begin
      @(posedge i_lclk);
      #1;
    end
    @(posedge i_lclk);
    #1;
    o_req_valid = 1'b0;
    o_req       = ~o_req; // Stale fields must not look valid
    for (int n = 0; n < 40 && i_rsp_valid !== 1'b1; n++) begin
      @(posedge i_lclk);
      #1;
    end
    rdata = (i_rsp_valid === 1'b1) ? i_rsp_data : 'x;
  endtask : access
endmodule : miac_host

// >>> tb/test_magnetometer_interrupt_axis_control.sv
// Self-checking bench for the interrupt and axis control core
module test_magnetometer_interrupt_axis_control;
  import miac_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic               mclk = 0, lclk = 0, rst_n = 0, meas_valid = 0;
  logic               req_valid, req_ready, rsp_valid, data_ready_pin_pin, int_pin;
  logic [7:0]         rsp_data, lo, hi, ien;
  logic signed [15:0] x, y, z;
  miac_req_t          req;
  miac_meas_t         meas = '0, m;
  miac_data_t         data, ed;
  int                 miscompares = 0, tests_run = 0, seed = 57918;

  // Core clock and an unrelated link clock
  always #2 mclk = ~mclk;
  always #7.5 lclk = ~lclk;

  miac_core i_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_lclk(lclk),
    .i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .i_meas_valid(meas_valid), .i_meas(meas), .o_data(data),
    .o_data_ready_pin(data_ready_pin_pin), .o_int_pin(int_pin));

  miac_host i_host (.i_lclk(lclk), .o_req_valid(req_valid), .o_req(req),
    .i_req_ready(req_ready), .i_rsp_valid(rsp_valid),
    .i_rsp_data(rsp_data));

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk8(input logic [7:0] got, input logic [7:0] want);
    tests_run++;
    if (got !== want) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk8

  task automatic chkd(input miac_data_t got, input miac_data_t want);
    tests_run++;
    if (got !== want) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chkd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host.access(1'b1, a, d, q);
    // A write with no response would otherwise pass unseen
    if ($isunknown(q)) begin
      chk8(q, 8'h00);
    end
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] want);
    logic [7:0] q;
    i_host.access(1'b0, a, 8'h00, q);
    chk8(q, want);
  endtask : rdc

  // One measurement pulse, then settle past the pin stage
  task automatic send(input logic ovf);
    @(posedge mclk);
    #1;
    meas_valid = 1'b1;
    meas = '{x: x, y: y, z: z, rhall: 14'($random(seed)), ovf: ovf};
    m = meas;
    @(posedge mclk);
    #1;
    meas_valid = 1'b0;
    meas = 63'({$random(seed), $random(seed)}); // Bus not held
    repeat (4) @(posedge mclk);
    #1;
  endtask : send

  task automatic pins(input logic d, input logic i);
    repeat (2) @(posedge mclk);
    #1;
    chk8({7'h00, data_ready_pin_pin}, {7'h00, d});
    chk8({7'h00, int_pin}, {7'h00, i});
  endtask : pins

  // Expected status from held values and scaled limits
  function automatic logic [7:0] exp_stat(miac_data_t d, logic [7:0] en,
                                          logic ovf);
    logic signed [15:0] l, h;
    l = $signed(lo);
    h = $signed(hi);
    l = l <<< LIM_SHIFT_DEF;
    h = h <<< LIM_SHIFT_DEF;
    return {1'b0, ovf, {d.z > h, d.y > h, d.x > h,
                        d.z < l, d.y < l, d.x < l} & ~en[5:0]};
  endfunction : exp_stat

  // Watchdog sized well above the expected run
  initial begin
    #60000;
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge lclk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge lclk);
    rdc(ADDR_IEN, IEN_RST);
    rdc(ADDR_PAC, PAC_RST);
    rdc(ADDR_LOW, LIM_RST);
    rdc(ADDR_HIGH, LIM_RST);
    rdc(ADDR_STAT, 8'h00);
    rdc(8'h60, 8'h00);
    // Random limits, enables and samples; first pass sits on the edges
    for (int i = 0; i < 6; i++) begin
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      ien = {2'b00, 6'($random(seed))};
      x = 16'($random(seed));
      y = 16'($random(seed));
      z = 16'($random(seed));
      if (i == 0) begin
        x = {{4{hi[7]}}, hi, 4'h0};
        y = x + 16'h0001;
        z = {{4{lo[7]}}, lo, 4'h0} - 16'h0001;
      end
      if (i == 5) begin
        x = 16'h8000; // Below any limit, held later with x disabled
      end
      wr(ADDR_LOW, lo);
      wr(ADDR_HIGH, hi);
      wr(ADDR_IEN, ien);
      rdc(ADDR_LOW, lo);
      rdc(ADDR_HIGH, hi);
      rdc(ADDR_IEN, ien);
      send(i[0]);
      ed = {m.x, m.y, m.z, m.rhall};
      chkd(data, ed);
      pins(1'b0, 1'b0);
      rdc(ADDR_STAT, exp_stat(ed, ien, i[0]));
      rdc(ADDR_RH_MSB, m.rhall[13:6]);
      rdc(ADDR_DATA_READY_PIN, {m.rhall[5:0], 2'b01});
      rdc(ADDR_DATA_READY_PIN, {m.rhall[5:0], 2'b00});
    end
    // Disabled channels hold, resistance zero, flags still evaluated
    ien = 8'h00;
    wr(ADDR_IEN, ien);
    wr(ADDR_PAC, 8'h3F);
    ed = {m.x, m.y, m.z, 14'h0000};
    x = 16'($random(seed));
    send(1'b0);
    chkd(data, ed);
    rdc(ADDR_STAT, exp_stat(ed, ien, 1'b0));
    rdc(ADDR_DATA_READY_PIN, 8'h01);
    wr(ADDR_PAC, PAC_RST);
    // Latched pin, polarity swaps, then follow mode
    wr(ADDR_LOW, 8'h80);
    wr(ADDR_HIGH, 8'h00);
    wr(ADDR_IEN, 8'h37);
    wr(ADDR_PAC, 8'h47);
    x = 16'h0100;
    y = 16'h0000;
    z = 16'h0000;
    send(1'b0);
    pins(1'b0, 1'b1);
    wr(ADDR_PAC, 8'hC6);
    pins(1'b1, 1'b0);
    rdc(ADDR_STAT, 8'h08);
    pins(1'b1, 1'b1);
    rdc(ADDR_DATA_READY_PIN, {m.rhall[5:0], 2'b01});
    pins(1'b0, 1'b1);
    wr(ADDR_PAC, 8'hC0);
    pins(1'b1, 1'b0);
    rdc(ADDR_STAT, 8'h08);
    pins(1'b1, 1'b0);
    // Overflow onto the pin only when its enable is set, active high
    wr(ADDR_PAC, 8'hC1);
    wr(ADDR_IEN, 8'h7F);
    x = 16'h0000;
    send(1'b1);
    pins(1'b0, 1'b1);
    wr(ADDR_IEN, 8'h3F);
    pins(1'b0, 1'b0);
    // Back-to-back samples flag overrun only when enabled
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_IEN, {e[0], 7'h3F});
      send(1'b0);
      send(1'b0);
      rdc(ADDR_STAT, {e[0], 7'h00});
      rdc(ADDR_DATA_READY_PIN, {m.rhall[5:0], 2'b01});
    end
    stop_test();
  end
endmodule : test_magnetometer_interrupt_axis_control
